/* File: dv/power_ctl_model.sv */
`timescale 1ns/1ps
// Upstream power controller: supply, reference clock, fundamental reset
module power_ctl_model #(
  parameter int CLK_LEAD = 8,
  parameter int REL_WAIT = 2200
)(
  input  wire logic core_clk,
  input  wire logic power_on,
  output logic      core_supply_sense,
  output logic      link_reference_clock,
  output logic      fundamental_reset_in_n
);
  int   cnt;
  logic clk_on_q;

  // Reset low before any supply is applied
  initial
  begin
    core_supply_sense = 1'b0;
    link_reference_clock = 1'b0;
    fundamental_reset_in_n = 1'b0;
    clk_on_q = 1'b0;
    cnt = 0;
  end

  // Up: supply, then clock, then late release; down: reverse order
  always @(negedge core_clk)
  begin
    if (power_on)
    begin
      core_supply_sense <= 1'b1;
      if (cnt < CLK_LEAD + REL_WAIT)
        cnt <= cnt + 1;
      clk_on_q <= (cnt >= CLK_LEAD);
      if (cnt >= CLK_LEAD + REL_WAIT)
        fundamental_reset_in_n <= 1'b1;
    end
    else
    begin
      cnt <= 0;
      if (fundamental_reset_in_n)
        fundamental_reset_in_n <= 1'b0;
      else if (clk_on_q)
        clk_on_q <= 1'b0;
      else
        core_supply_sense <= 1'b0;
    end
    if (clk_on_q)
      link_reference_clock <= ~link_reference_clock;
  end
endmodule

/* File: dv/test_bridge_reset_sequencer.sv */
`timescale 1ns/1ps
module test_bridge_reset_sequencer;
  logic       core_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       power_on = 1'b0;
  logic       core_supply_sense;
  logic       link_reference_clock;
  logic       fundamental_reset_in_n;
  logic       global_reset_in_n = 1'b1;
  logic       hot_reset_in = 1'b0;
  logic       link_up_in = 1'b0;
  logic       secondary_reset_ctl_bit = 1'b0;
  logic [7:0] strap_in = 8'h00;
  logic       eeprom_present_in = 1'b0;
  logic       eeprom_dl_done_in = 1'b0;
  logic       por_rst_out;
  logic       pcie_rst_out;
  logic       link_down_state;
  logic       secondary_bus_reset_out_n;
  logic [7:0] strap_q;
  logic       eeprom_dl_start;
  logic       link_cfg_start;
  logic       link_train_en;
  int         fail_count = 0;
  int         check_count = 0;

  // 200 MHz clock
  always #2.5 core_clk = ~core_clk;

  power_ctl_model pwr (
    .core_clk              (core_clk),
    .power_on              (power_on),
    .core_supply_sense     (core_supply_sense),
    .link_reference_clock  (link_reference_clock),
    .fundamental_reset_in_n(fundamental_reset_in_n)
  );

  bridge_reset_sequencer #(.STRAP_W(8), .TRAIN_MAX_CYC(50)) dut (
    .core_clk                 (core_clk),
    .sys_rst                  (sys_rst),
    .core_supply_sense        (core_supply_sense),
    .link_reference_clock     (link_reference_clock),
    .global_reset_in_n        (global_reset_in_n),
    .fundamental_reset_in_n   (fundamental_reset_in_n),
    .hot_reset_in             (hot_reset_in),
    .link_up_in               (link_up_in),
    .secondary_reset_ctl_bit  (secondary_reset_ctl_bit),
    .strap_in                 (strap_in),
    .eeprom_present_in        (eeprom_present_in),
    .eeprom_dl_done_in        (eeprom_dl_done_in),
    .por_rst_out              (por_rst_out),
    .pcie_rst_out             (pcie_rst_out),
    .link_down_state          (link_down_state),
    .secondary_bus_reset_out_n(secondary_bus_reset_out_n),
    .strap_q                  (strap_q),
    .eeprom_dl_start          (eeprom_dl_start),
    .link_cfg_start           (link_cfg_start),
    .link_train_en            (link_train_en)
  );

  // Verdict and end of run
  task automatic results();
    if (fail_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Bounded wait for a level; running out ends the run
  task automatic wait_lvl(ref logic s, input logic v, input int bound);
    int n;
    n = 0;
    while (s !== v && n < bound)
    begin
      @(negedge core_clk);
      n++;
    end
    if (s !== v)
    begin
      fail_count++;
      $display("[ERR] %0t wait bound used up", $time);
      results();
    end
  endtask

  // Power-up, settle time, fundamental release and launch
  task automatic t_power_up();
    strap_in = 8'ha5;
    power_on = 1'b1;
    tick(1990);
    check(8'(por_rst_out), 8'h01);
    check(8'(secondary_bus_reset_out_n), 8'h00);
    wait_lvl(por_rst_out, 1'b0, 100);
    check(8'(pcie_rst_out), 8'h01);
    wait_lvl(link_cfg_start, 1'b1, 400);
    check(strap_q, 8'ha5);
    check(8'(eeprom_dl_start), 8'h00);
    tick(1);
    check(8'(link_cfg_start), 8'h00);
    check(8'(link_train_en), 8'h01);
    tick(2);
    check(8'(secondary_bus_reset_out_n), 8'h01);
  endtask

  // Software bit drives bus reset both ways
  task automatic t_sw_bit();
    secondary_reset_ctl_bit = 1'b1;
    tick(3);
    check(8'(secondary_bus_reset_out_n), 8'h00);
    secondary_reset_ctl_bit = 1'b0;
    tick(3);
    check(8'(secondary_bus_reset_out_n), 8'h01);
  endtask

  // Hot reset enters link-down until the link comes back
  task automatic t_hot_reset();
    hot_reset_in = 1'b1;
    tick(1);
    hot_reset_in = 1'b0;
    tick(2);
    check(8'(link_down_state), 8'h01);
    check(8'(secondary_bus_reset_out_n), 8'h00);
    link_up_in = 1'b1;
    tick(1);
    link_up_in = 1'b0;
    tick(2);
    check(8'(link_down_state), 8'h00);
    check(8'(secondary_bus_reset_out_n), 8'h01);
  endtask

  // Global reset without a clock edge, then launch with download
  task automatic t_global();
    strap_in = 8'h3c;
    eeprom_present_in = 1'b1;
    global_reset_in_n = 1'b0;
    #1;
    check(8'(por_rst_out), 8'h01);
    check(8'(secondary_bus_reset_out_n), 8'h00);
    tick(3);
    check(8'(pcie_rst_out), 8'h01);
    global_reset_in_n = 1'b1;
    wait_lvl(link_cfg_start, 1'b1, 8);
    check(strap_q, 8'h3c);
    check(8'(eeprom_dl_start), 8'h01);
    check(8'(link_train_en), 8'h00);
    wait_lvl(por_rst_out, 1'b0, 2100);
    check(8'(link_train_en), 8'h01);
    wait_lvl(link_train_en, 1'b1, 4);
    eeprom_present_in = 1'b0;
  endtask

  // Power-down: fundamental first, then supply loss
  task automatic t_power_down();
    power_on = 1'b0;
    wait_lvl(fundamental_reset_in_n, 1'b0, 4);
    tick(2);
    check(8'(pcie_rst_out), 8'h01);
    check(8'(secondary_bus_reset_out_n), 8'h00);
    check(8'(link_train_en), 8'h00);
    wait_lvl(core_supply_sense, 1'b0, 8);
    tick(2);
    check(8'(por_rst_out), 8'h01);
  endtask

  // Fundamental release with download: training waits for it
  task automatic t_dl_wait();
    strap_in = 8'h5a;
    eeprom_present_in = 1'b1;
    power_on = 1'b1;
    wait_lvl(link_cfg_start, 1'b1, 2400);
    check(strap_q, 8'h5a);
    check(8'(eeprom_dl_start), 8'h01);
    tick(8);
    check(8'(link_train_en), 8'h00);
    eeprom_dl_done_in = 1'b1;
    tick(1);
    eeprom_dl_done_in = 1'b0;
    tick(1);
    check(8'(link_train_en), 8'h01);
  endtask

  // Main sequence
  initial
  begin
    tick(16);
    sys_rst = 1'b0;
    tick(1);
    check(8'(por_rst_out), 8'h01);
    t_power_up();
    t_sw_bit();
    t_hot_reset();
    t_global();
    t_power_down();
    t_dl_wait();
    results();
  end
endmodule

/* File: rtl/bridge_reset_sequencer.sv */
`timescale 1ns/1ps
`include "bridge_reset_cfg.svh"
module bridge_reset_sequencer
  import bridge_reset_pkg::*;
#(
  parameter int STRAP_W       = `STRAP_W,
  parameter int TRAIN_MAX_CYC = `TRAIN_MAX_CYC
)(
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  input  wire logic               core_supply_sense,
  input  wire logic               link_reference_clock,
  input  wire logic               global_reset_in_n,
  input  wire logic               fundamental_reset_in_n,
  input  wire logic               hot_reset_in,
  input  wire logic               link_up_in,
  input  wire logic               secondary_reset_ctl_bit,
  input  wire logic [STRAP_W-1:0] strap_in,
  input  wire logic               eeprom_present_in,
  input  wire logic               eeprom_dl_done_in,
  output logic                    por_rst_out,
  output logic                    pcie_rst_out,
  output logic                    link_down_state,
  output logic                    secondary_bus_reset_out_n,
  output logic [STRAP_W-1:0]      strap_q,
  output logic                    eeprom_dl_start,
  output logic                    link_cfg_start,
  output logic                    link_train_en
);

  por_state_t state_q;
  por_state_t state_d;
  logic       ref_q;
  logic       ref_edge;
  logic       global_reset_in_n_q1;
  logic       global_reset_in_n_q2;
  logic       global_reset_in_n_q3;
  logic       global_reset_in_n_rise;
  logic       fundamental_reset_in_n_q;
  logic       fundamental_reset_in_n_rise;
  logic       launch;
  logic       por_active;
  logic       pcie_active;
  logic       rst_any;
  logic       dl_pending_q;
  logic       train_req_q;
  logic       train_kill;

  seq_timer_if settle_if ();
  seq_timer_if train_if ();

  // Reference clock activity, input taken as synchronous
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      ref_q <= 1'b0;
    else
      ref_q <= link_reference_clock;
  end
  assign ref_edge = ref_q ^ link_reference_clock;

  // Power-on sequence next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      S_WAIT_PWR:
        if (core_supply_sense)
          state_d = S_WAIT_CLK;
      S_WAIT_CLK:
        if (!core_supply_sense)
          state_d = S_WAIT_PWR;
        else if (ref_edge)
          state_d = S_SETTLE;
      S_SETTLE:
        if (!core_supply_sense)
          state_d = S_WAIT_PWR;
        else if (settle_if.done)
          state_d = S_RUN;
      S_RUN:
        if (!core_supply_sense)
          state_d = S_WAIT_PWR;
      default:
        state_d = S_WAIT_PWR;
    endcase
  end

  // Global reset low restarts the sequence without a clock
  always_ff @(posedge core_clk or negedge global_reset_in_n)
  begin
    if (!global_reset_in_n)
      state_q <= S_WAIT_PWR;
    else if (sys_rst)
      state_q <= S_WAIT_PWR;
    else
      state_q <= state_d;
  end

  // Settle timer runs only while settling
  assign settle_if.start = (state_q == S_WAIT_CLK) && ref_edge
                           && core_supply_sense;
  assign settle_if.clear = (state_q != S_SETTLE) && !settle_if.start;

  seq_timer #(
    .CNT_W (`SETTLE_CNT_W)
  ) u_settle (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .limit    (`SETTLE_CNT_W'(`SETTLE_CYC)),
    .tmr      (settle_if)
  );

  // Global reset release detect, cleared asynchronously
  always_ff @(posedge core_clk or negedge global_reset_in_n)
  begin
    if (!global_reset_in_n)
    begin
      global_reset_in_n_q1 <= 1'b0;
      global_reset_in_n_q2 <= 1'b0;
      global_reset_in_n_q3 <= 1'b0;
    end
    else
    begin
      global_reset_in_n_q1 <= 1'b1;
      global_reset_in_n_q2 <= global_reset_in_n_q1;
      global_reset_in_n_q3 <= global_reset_in_n_q2;
    end
  end
  assign global_reset_in_n_rise = global_reset_in_n_q2 && !global_reset_in_n_q3;  // Only the settled stages q2 and q3 are read

  // Fundamental reset rise doubles as power good
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      fundamental_reset_in_n_q <= 1'b0;
    else
      fundamental_reset_in_n_q <= fundamental_reset_in_n;
  end
  assign fundamental_reset_in_n_rise = fundamental_reset_in_n && !fundamental_reset_in_n_q;

  assign launch      = global_reset_in_n_rise || fundamental_reset_in_n_rise;
  assign por_active  = (state_q != S_RUN) || !global_reset_in_n
                       || !core_supply_sense;
  assign train_kill  = !global_reset_in_n || !fundamental_reset_in_n
                       || !core_supply_sense;
  assign pcie_active = por_active || !fundamental_reset_in_n;
  assign rst_any     = pcie_active || link_down_state
                       || secondary_reset_ctl_bit;

  // Scope outputs, global reset forces them at once
  always_ff @(posedge core_clk or negedge global_reset_in_n)
  begin
    if (!global_reset_in_n)
    begin
      por_rst_out               <= 1'b1;
      pcie_rst_out              <= 1'b1;
      secondary_bus_reset_out_n <= `SEC_RST_N_RST;
    end
    else if (sys_rst)
    begin
      por_rst_out               <= 1'b1;
      pcie_rst_out              <= 1'b1;
      secondary_bus_reset_out_n <= `SEC_RST_N_RST;
    end
    else
    begin
      por_rst_out               <= por_active;
      pcie_rst_out              <= pcie_active;
      secondary_bus_reset_out_n <= !rst_any;
    end
  end

  // Link-down state, hot reset set wins over link-up clear
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      link_down_state <= 1'b0;
    else if (hot_reset_in)
      link_down_state <= 1'b1;
    else if (link_up_in || pcie_active)
      link_down_state <= 1'b0;
  end

  // Strap capture and start pulses on reset release
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      strap_q         <= STRAP_W'(`STRAP_RST);
      eeprom_dl_start <= 1'b0;
      link_cfg_start  <= 1'b0;
    end
    else
    begin
      if (launch)
        strap_q <= strap_in;
      eeprom_dl_start <= launch && eeprom_present_in;
      link_cfg_start  <= launch;
    end
  end

  // Training bound timer, started by each release
  assign train_if.start = launch;
  assign train_if.clear = train_kill && !launch;

  seq_timer #(
    .CNT_W (`TRAIN_CNT_W)
  ) u_train (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .limit    (`TRAIN_CNT_W'(TRAIN_MAX_CYC)),
    .tmr      (train_if)
  );

  // Launch arms training, kept through the settle after global release
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || (train_kill && !launch))
    begin
      train_req_q  <= 1'b0;
      dl_pending_q <= 1'b0;
    end
    else if (launch)
    begin
      train_req_q  <= 1'b1;
      dl_pending_q <= eeprom_present_in;
    end
    else if (eeprom_dl_done_in)
      dl_pending_q <= 1'b0;
  end

  // Train after download or at the bound, never while pcie_active
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || launch || pcie_active)
      link_train_en <= 1'b0;
    else if (train_req_q && (!dl_pending_q || train_if.done))
      link_train_en <= 1'b1;
  end

  // Helper: cycles spent settling
  logic [15:0] settle_chk_q;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || state_q != S_SETTLE)
      settle_chk_q <= '0;
    else
      settle_chk_q <= settle_chk_q + 16'h0001;
  end

  property p_pwr_hold;
    @(posedge core_clk) disable iff (sys_rst)
    !core_supply_sense |=> por_rst_out;
  endproperty
  a_pwr_hold: assert property (p_pwr_hold)
    else $error("power-on reset released without supply");

  property p_settle_time;
    @(posedge core_clk) disable iff (sys_rst)
    (state_q == S_SETTLE && state_d == S_RUN && global_reset_in_n)
      |-> settle_chk_q == 16'(`SETTLE_CYC);
  endproperty
  a_settle_time: assert property (p_settle_time)
    else $error("settle time wrong");

  property p_por_scope;
    @(posedge core_clk) disable iff (sys_rst)
    por_rst_out |-> pcie_rst_out && !secondary_bus_reset_out_n;
  endproperty
  a_por_scope: assert property (p_por_scope)
    else $error("power-on reset scope incomplete");

  property p_global_reset_in_n_low;
    @(posedge core_clk) disable iff (sys_rst)
    !global_reset_in_n |-> por_rst_out && !secondary_bus_reset_out_n
      && state_q == S_WAIT_PWR;
  endproperty
  a_global_reset_in_n_low: assert property (p_global_reset_in_n_low)
    else $error("global reset not applied");

  property p_strap_latch;
    @(posedge core_clk) disable iff (sys_rst)
    launch |=> strap_q == $past(strap_in) && link_cfg_start;
  endproperty
  a_strap_latch: assert property (p_strap_latch)
    else $error("straps not latched on release");

  property p_train_bound;
    @(posedge core_clk) disable iff (sys_rst)
    (train_if.done && !pcie_active) |=> link_train_en;
  endproperty
  a_train_bound: assert property (p_train_bound)
    else $error("training not started at bound");

  property p_fundamental_reset_in_n_low;
    @(posedge core_clk) disable iff (sys_rst)
    !fundamental_reset_in_n ##1 !fundamental_reset_in_n
      |-> pcie_rst_out && !secondary_bus_reset_out_n && !link_train_en;
  endproperty
  a_fundamental_reset_in_n_low: assert property (p_fundamental_reset_in_n_low)
    else $error("fundamental reset not applied");

  property p_hot_reset;
    @(posedge core_clk) disable iff (sys_rst)
    hot_reset_in |=> link_down_state ##1 !secondary_bus_reset_out_n;
  endproperty
  a_hot_reset: assert property (p_hot_reset)
    else $error("hot reset did not enter link-down");

  property p_sw_bit;
    @(posedge core_clk) disable iff (sys_rst)
    secondary_reset_ctl_bit |=> !secondary_bus_reset_out_n;
  endproperty
  a_sw_bit: assert property (p_sw_bit)
    else $error("software bit did not assert bus reset");

  property p_or_release;
    @(posedge core_clk) disable iff (sys_rst || !global_reset_in_n)
    !rst_any |=> secondary_bus_reset_out_n;
  endproperty
  a_or_release: assert property (p_or_release)
    else $error("bus reset held with no source");

  c_por_release: cover property (@(posedge core_clk) disable iff (sys_rst)
    $fell(por_rst_out));
  c_fundamental_reset_in_n_train: cover property (@(posedge core_clk) disable iff (sys_rst)
    fundamental_reset_in_n_rise ##[1:20] link_train_en);
  c_hot_reset: cover property (@(posedge core_clk) disable iff (sys_rst)
    hot_reset_in ##[1:20] !link_down_state);

endmodule

/* File: rtl/seq_timer.sv */
`timescale 1ns/1ps
module seq_timer
  import bridge_reset_pkg::*;
#(
  parameter int CNT_W = 12
)(
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic [CNT_W-1:0] limit,
  seq_timer_if.timer            tmr
);

  logic             busy_q;
  logic             done_q;
  logic [CNT_W-1:0] cnt_q;

  // Count limit cycles after start, then hold done until restarted or cleared
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || tmr.clear)
    begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      cnt_q  <= '0;
    end
    else if (tmr.start)
    begin
      busy_q <= 1'b1;
      done_q <= 1'b0;
      cnt_q  <= '0;
    end
    else if (busy_q)
    begin
      if (cnt_q == limit - CNT_W'(1))
      begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  assign tmr.done = done_q;

endmodule

/* File: shared/bridge_reset_cfg.svh */
`ifndef BRIDGE_RESET_CFG_SVH
`define BRIDGE_RESET_CFG_SVH

// Clock and timing
`define CLK_PERIOD_NS 5
`define SETTLE_TIME_US 10
`define TRAIN_MAX_MS 80
`define SETTLE_CYC \
  ((`SETTLE_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TRAIN_MAX_CYC ((`TRAIN_MAX_MS * 1000000) / `CLK_PERIOD_NS)
`define SETTLE_CNT_W 12
`define TRAIN_CNT_W 24

// Widths and reset values
`define STRAP_W 8
`define STRAP_RST 8'h00
`define SEC_RST_N_RST 1'b0

`endif

/* File: shared/bridge_reset_pkg.sv */
package bridge_reset_pkg;

  // Power-on sequence states
  typedef enum logic [1:0] {
    S_WAIT_PWR = 2'b00,
    S_WAIT_CLK = 2'b01,
    S_SETTLE   = 2'b10,
    S_RUN      = 2'b11
  } por_state_t;

endpackage

/* File: shared/seq_timer_if.sv */
`timescale 1ns/1ps
interface seq_timer_if;
  logic start;
  logic clear;
  logic done;

  modport ctrl  (output start, output clear, input done);
  modport timer (input start, input clear, output done);
endinterface
